// File: include/gfx_pkg.sv
// Purpose: Shared constants for the planar graphics datapath
// Assumes: Four 8-bit planes, byte-wide register ports
// Notes: Offsets, field positions, reset values and mode codes
package gfx_pkg;
    // Port addresses, same in I/O and memory space
    localparam logic [15:0] INDEX_PORT = 16'h03ce;
    localparam logic [15:0] DATA_PORT = 16'h03cf;

    // Register indices behind the data port
    localparam logic [3:0] IDX_FILL_VALUE = 4'h0;
    localparam logic [3:0] IDX_FILL_ENABLE = 4'h1;
    localparam logic [3:0] IDX_COMPARE = 4'h2;
    localparam logic [3:0] IDX_ROTATE_OP = 4'h3;
    localparam logic [3:0] IDX_READ_PLANE = 4'h4;
    localparam logic [3:0] IDX_MODE = 4'h5;
    localparam logic [3:0] IDX_IGNORE = 4'h7;
    localparam logic [3:0] IDX_BIT_MASK = 4'h8;

    // Field positions
    localparam int ROT_CNT_LSB = 0;
    localparam int ROT_FN_LSB = 3;
    localparam int MODE_WR_LSB = 0;
    localparam int MODE_RD_BIT = 3;
    localparam int MODE_OE_BIT = 4;
    localparam int MODE_SHIFT_LSB = 5;

    // Values after reset
    localparam logic [3:0] RST_NIBBLE = 4'h0;
    localparam logic [4:0] RST_ROTATE_OP = 5'h00;
    localparam logic [1:0] RST_READ_PLANE = 2'h0;
    localparam logic [5:0] RST_MODE = 6'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Write modes
    typedef enum logic [1:0] {
        WR_MODE0 = 2'h0,
        WR_MODE1 = 2'h1,
        WR_MODE2 = 2'h2,
        WR_MODE3 = 2'h3
    } wr_mode_t;

    // Logical functions against the read latch
    typedef enum logic [1:0] {
        FN_PASS = 2'h0,
        FN_AND = 2'h1,
        FN_OR = 2'h2,
        FN_XOR = 2'h3
    } logic_fn_t;

    // Index of the last transfer per loaded word in the serializer
    localparam logic [2:0] XFER_LAST = 3'h7;
endpackage

// File: rtl/plane_write_path.sv
// Purpose: Combinational write data path for one plane set
// Assumes: Latches hold the last frame-buffer read
// Notes: Rotate, substitute, logic op, then bit-mask merge
module plane_write_path (
    input wire logic [7:0] cpu_data,
    input wire logic [31:0] latch_data,
    input wire logic [3:0] set_reset_value,
    input wire logic [3:0] set_reset_enable,
    input wire logic [2:0] rotate_count,
    input wire logic [1:0] logic_fn,
    input wire logic [1:0] write_mode,
    input wire logic [7:0] bit_mask,
    output logic [31:0] plane_data
);
    logic [15:0] doubled;
    logic [7:0] rotated;

    // Right rotation through a doubled copy
    assign doubled = {cpu_data, cpu_data} >> rotate_count;
    assign rotated = doubled[7:0];

    for (genvar p = 0; p < 4; p++) begin : g_plane
        logic [7:0] latch;
        logic [7:0] src;
        logic [7:0] fn_out;
        logic [7:0] mask;
        assign latch = latch_data[p*8 +: 8];

        // Stage order: rotate, substitute, logic, mask
        always_comb begin
            src = rotated;
            fn_out = rotated;
            mask = bit_mask;
            case (write_mode)
                gfx_pkg::WR_MODE0: begin
                    src = set_reset_enable[p] ? {8{set_reset_value[p]}} : rotated;
                    case (logic_fn)
                        gfx_pkg::FN_AND: fn_out = src & latch;
                        gfx_pkg::FN_OR: fn_out = src | latch;
                        gfx_pkg::FN_XOR: fn_out = src ^ latch;
                        default: fn_out = src;
                    endcase
                end
                gfx_pkg::WR_MODE1: begin
                    fn_out = latch;
                end
                gfx_pkg::WR_MODE2: begin
                    fn_out = {8{cpu_data[p]}};
                end
                default: begin
                    fn_out = {8{set_reset_value[p]}};
                    mask = rotated & bit_mask;
                end
            endcase
        end

        // Clear mask bits keep latch data in every mode
        assign plane_data[p*8 +: 8] = (fn_out & mask) | (latch & ~mask);
    end
endmodule

// File: rtl/plane_serializer.sv
// Purpose: Turns four plane bytes into 4-bit transfers
// Assumes: Load and transfer strobes come from video fetch
// Notes: Eight transfers per load in every shift format
module plane_serializer (
    input wire logic clk,
    input wire logic srst,
    input wire logic [1:0] shift_ctrl,
    input wire logic load,
    input wire logic [31:0] load_data,
    input wire logic xfer,
    output logic [3:0] serial_out
);
    logic [31:0] bytes_ff;
    logic [2:0] cnt_ff;
    logic [3:0] nxt_serial;
    logic [7:0] b0, b1, b2, b3;
    logic [7:0] lo_byte, hi_byte, nib_byte;
    logic [2:0] hi_bit, lo_bit;

    assign b0 = bytes_ff[7:0];
    assign b1 = bytes_ff[15:8];
    assign b2 = bytes_ff[23:16];
    assign b3 = bytes_ff[31:24];
    assign lo_byte = cnt_ff[2] ? b1 : b0;
    assign hi_byte = cnt_ff[2] ? b3 : b2;
    assign hi_bit = {~cnt_ff[1:0], 1'b1};
    assign lo_bit = {~cnt_ff[1:0], 1'b0};
    assign nib_byte = bytes_ff[{cnt_ff[2:1], 3'h0} +: 8];

    // Pick the nibble for the current transfer
    always_comb begin
        case (shift_ctrl)
            2'h0: nxt_serial = {b3[~cnt_ff], b2[~cnt_ff], b1[~cnt_ff], b0[~cnt_ff]};
            2'h1: nxt_serial = {hi_byte[hi_bit], hi_byte[lo_bit], lo_byte[hi_bit], lo_byte[lo_bit]};
            default: nxt_serial = cnt_ff[0] ? nib_byte[3:0] : nib_byte[7:4];
        endcase
    end

    // Load restarts the sequence even mid-word
    always_ff @(posedge clk) begin
        if (srst) begin
            bytes_ff <= 32'h0000_0000;
            cnt_ff <= 3'h0;
            serial_out <= 4'h0;
        end else if (load) begin
            bytes_ff <= load_data;
            cnt_ff <= 3'h0;
        end else if (xfer) begin
            serial_out <= nxt_serial;
            cnt_ff <= (cnt_ff == gfx_pkg::XFER_LAST) ? cnt_ff : cnt_ff + 3'h1;
        end
    end
endmodule

// File: rtl/planar_graphics_datapath.sv
// Purpose: Graphics register file and planar frame-buffer datapath
// Assumes: Plane memory answers reads in the same cycle
// Notes: Register and frame-buffer answers arrive one cycle later
// Notes on behaviour
// - Index port selects register behind data port
// - Index holds 4-bit selector, upper bits reserved
// - Mode 0 enabled planes get replicated fill bit
// - Fill enables act only in write mode 0
// - Mode 3 masks with rotated data, writes fill
// - Read mode 1 returns colour compare result
// - Function field combines data with latch, write mode 0 only
// - Write data rotated right by count
// - Read mode 0 returns selected plane
// - Chain-four overrides plane select, odd/even only its bit 0
// - Plane select also picks latch readback
// - Shift 00 sends one bit per plane
// - Shift 01 sends bit pairs, even planes first
// - Shift 1x sends nibbles plane by plane
// - Reserved register bits read as zero
// - Write mode 1 stores the read latches
// - Write mode 2 uses low data as colour
// - Read mode bit picks plain or compare read
// - Clear bit-mask positions keep latch data
module planar_graphics_datapath #(
    parameter int ADDR_W = 16
) (
    input wire logic clk,
    input wire logic srst,
    // Register port access
    input wire logic [ADDR_W-1:0] io_addr,
    input wire logic io_mem_space,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_rvalid,
    // Frame-buffer access from the host
    input wire logic fb_wr,
    input wire logic fb_rd,
    input wire logic [1:0] fb_addr_lo,
    input wire logic [7:0] fb_wdata,
    output logic [7:0] fb_rdata,
    output logic fb_rvalid,
    // Addressing state from the sequencer
    input wire logic odd_even_addr,
    input wire logic chain_four_addr,
    input wire logic [3:0] plane_write_mask,
    // Plane memory at the addressed byte
    input wire logic [31:0] plane_rdata,
    output logic [31:0] plane_wdata,
    output logic [3:0] plane_we,
    // Latch readback seen by the CRT register file
    output logic [7:0] latch_readback,
    // Video side
    input wire logic vid_load,
    input wire logic vid_xfer,
    output logic [3:0] serial_out
);
    // Port addresses need ten address bits
    if (ADDR_W < 10) begin : g_bad_addr_w
        $error("ADDR_W too narrow for the port addresses");
    end


    ////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [3:0] index_ff;
    logic [3:0] set_reset_value_ff;
    logic [3:0] set_reset_enable_ff;
    logic [3:0] color_compare_value_ff;
    logic [4:0] rotate_and_logic_op_ff;
    logic [1:0] read_plane_select_ff;
    logic [5:0] graphics_mode_ff;
    logic [3:0] color_ignore_mask_ff;
    logic [7:0] bit_mask_ff;
    logic [31:0] latch_ff;

    logic hit_index;
    logic hit_data;
    logic [7:0] nxt_io_rdata;
    logic [7:0] mode_byte;
    logic [1:0] write_mode;
    logic [1:0] shift_ctrl;
    logic read_mode;

    ////////////////////////////////////////////////////////////////////////
    // Port decode, same for I/O and memory space
    // Space flag is accepted but does not steer decode
    assign hit_index = (ADDR_W'(gfx_pkg::INDEX_PORT) == io_addr);
    assign hit_data = (ADDR_W'(gfx_pkg::DATA_PORT) == io_addr);

    // Mode register split into its fields
    assign write_mode = graphics_mode_ff[gfx_pkg::MODE_WR_LSB +: 2];
    // Bit 2 is not stored, so fields above it sit one place lower
    assign read_mode = graphics_mode_ff[gfx_pkg::MODE_RD_BIT-1];
    assign shift_ctrl = graphics_mode_ff[gfx_pkg::MODE_SHIFT_LSB-1 +: 2];
    // Bits 7 and 2 are not stored, so they read back as zero
    assign mode_byte = {1'b0, graphics_mode_ff[5:2], 1'b0, graphics_mode_ff[1:0]};

    ////////////////////////////////////////////////////////////////////////
    // Index register
    always_ff @(posedge clk) begin
        if (srst) begin
            index_ff <= gfx_pkg::RST_NIBBLE;
        end else if (io_wr && hit_index) begin
            index_ff <= io_wdata[3:0];
        end
    end

    // Graphics registers behind the data port
    always_ff @(posedge clk) begin
        if (srst) begin
            set_reset_value_ff <= gfx_pkg::RST_NIBBLE;
            set_reset_enable_ff <= gfx_pkg::RST_NIBBLE;
            color_compare_value_ff <= gfx_pkg::RST_NIBBLE;
            rotate_and_logic_op_ff <= gfx_pkg::RST_ROTATE_OP;
            read_plane_select_ff <= gfx_pkg::RST_READ_PLANE;
            graphics_mode_ff <= gfx_pkg::RST_MODE;
            color_ignore_mask_ff <= gfx_pkg::RST_NIBBLE;
            bit_mask_ff <= gfx_pkg::RST_BYTE;
        end else if (io_wr && hit_data) begin
            case (index_ff)
                gfx_pkg::IDX_FILL_VALUE: set_reset_value_ff <= io_wdata[3:0];
                gfx_pkg::IDX_FILL_ENABLE: set_reset_enable_ff <= io_wdata[3:0];
                gfx_pkg::IDX_COMPARE: color_compare_value_ff <= io_wdata[3:0];
                gfx_pkg::IDX_ROTATE_OP: rotate_and_logic_op_ff <= io_wdata[4:0];
                gfx_pkg::IDX_READ_PLANE: read_plane_select_ff <= io_wdata[1:0];
                gfx_pkg::IDX_MODE: graphics_mode_ff <= {io_wdata[6:3], io_wdata[1:0]};
                gfx_pkg::IDX_IGNORE: color_ignore_mask_ff <= io_wdata[3:0];
                gfx_pkg::IDX_BIT_MASK: bit_mask_ff <= io_wdata;
                default: bit_mask_ff <= bit_mask_ff;
            endcase
        end
    end

    // Register read mux, reserved bits padded with zero
    always_comb begin
        nxt_io_rdata = 8'h00;
        if (hit_index) begin
            nxt_io_rdata = {4'h0, index_ff};
        end else if (hit_data) begin
            case (index_ff)
                gfx_pkg::IDX_FILL_VALUE: nxt_io_rdata = {4'h0, set_reset_value_ff};
                gfx_pkg::IDX_FILL_ENABLE: nxt_io_rdata = {4'h0, set_reset_enable_ff};
                gfx_pkg::IDX_COMPARE: nxt_io_rdata = {4'h0, color_compare_value_ff};
                gfx_pkg::IDX_ROTATE_OP: nxt_io_rdata = {3'h0, rotate_and_logic_op_ff};
                gfx_pkg::IDX_READ_PLANE: nxt_io_rdata = {6'h00, read_plane_select_ff};
                gfx_pkg::IDX_MODE: nxt_io_rdata = mode_byte;
                gfx_pkg::IDX_IGNORE: nxt_io_rdata = {4'h0, color_ignore_mask_ff};
                gfx_pkg::IDX_BIT_MASK: nxt_io_rdata = bit_mask_ff;
                default: nxt_io_rdata = 8'h00;
            endcase
        end
    end

    // Register answers one cycle after the read strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            io_rdata <= 8'h00;
            io_rvalid <= 1'b0;
        end else begin
            io_rvalid <= io_rd;
            if (io_rd) begin
                io_rdata <= nxt_io_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read side
    logic [1:0] rd_plane;
    logic [7:0] plane_byte;
    logic [7:0] compare_byte;
    logic [7:0] nxt_fb_rdata;

    // Chain-four overrides both select bits, odd/even only bit 0
    always_comb begin
        if (chain_four_addr) begin
            rd_plane = fb_addr_lo;
        end else if (odd_even_addr) begin
            rd_plane = {read_plane_select_ff[1], fb_addr_lo[0]};
        end else begin
            rd_plane = read_plane_select_ff;
        end
    end

    assign plane_byte = plane_rdata[{rd_plane, 3'h0} +: 8];

    // Colour compare: excluded planes always match
    for (genvar i = 0; i < 8; i++) begin : g_cmp
        logic [3:0] match;
        for (genvar p = 0; p < 4; p++) begin : g_pl
            assign match[p] = ~color_ignore_mask_ff[p]
                | (plane_rdata[p*8 + i] == color_compare_value_ff[p]);
        end
        assign compare_byte[i] = &match;
    end

    assign nxt_fb_rdata = read_mode ? compare_byte : plane_byte;

    // Data returned one cycle after the read strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            fb_rdata <= 8'h00;
            fb_rvalid <= 1'b0;
        end else begin
            fb_rvalid <= fb_rd;
            if (fb_rd) begin
                fb_rdata <= nxt_fb_rdata;
            end
        end
    end

    // All four latches reload on any frame-buffer read
    always_ff @(posedge clk) begin
        if (srst) begin
            latch_ff <= 32'h0000_0000;
        end else if (fb_rd) begin
            latch_ff <= plane_rdata;
        end
    end

    // Readback follows the select bits, not the address
    always_ff @(posedge clk) begin
        if (srst) begin
            latch_readback <= 8'h00;
        end else begin
            latch_readback <= latch_ff[{read_plane_select_ff, 3'h0} +: 8];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write side
    logic [31:0] wr_data;
    logic [3:0] addr_planes;

    plane_write_path u_write_path (
        .cpu_data(fb_wdata),
        .latch_data(latch_ff),
        .set_reset_value(set_reset_value_ff),
        .set_reset_enable(set_reset_enable_ff),
        .rotate_count(rotate_and_logic_op_ff[gfx_pkg::ROT_CNT_LSB +: 3]),
        .logic_fn(rotate_and_logic_op_ff[gfx_pkg::ROT_FN_LSB +: 2]),
        .write_mode(write_mode),
        .bit_mask(bit_mask_ff),
        .plane_data(wr_data)
    );

    // Address bits narrow the planes reached in chained modes
    always_comb begin
        if (chain_four_addr) begin
            addr_planes = 4'h1 << fb_addr_lo;
        end else if (odd_even_addr) begin
            addr_planes = fb_addr_lo[0] ? 4'ha : 4'h5;
        end else begin
            addr_planes = 4'hf;
        end
    end

    // Plane write issued one cycle after the host strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            plane_wdata <= 32'h0000_0000;
            plane_we <= 4'h0;
        end else begin
            plane_we <= fb_wr ? (addr_planes & plane_write_mask) : 4'h0;
            if (fb_wr) begin
                plane_wdata <= wr_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serializer to the palette
    plane_serializer u_serializer (
        .clk(clk),
        .srst(srst),
        .shift_ctrl(shift_ctrl),
        .load(vid_load),
        .load_data(plane_rdata),
        .xfer(vid_xfer),
        .serial_out(serial_out)
    );
endmodule

// File: test/plane_store.sv
// Purpose: Plane memory model at the addressed byte
// Assumes: Byte lanes planes 3..0, write on plane_we
// Notes: Content after reset is an arbitrary pattern
module plane_store #(
    parameter logic [31:0] INIT = 32'h33cc_0ff0
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [3:0] plane_we,
    input wire logic [31:0] plane_wdata,
    output logic [31:0] plane_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] cell_ff;

    // Per-plane byte write; read is combinational as the datapath expects
    always_ff @(posedge clk) begin
        if (srst) begin
            cell_ff <= INIT;
        end else begin
            for (int p = 0; p < 4; p++) begin
                if (plane_we[p]) begin
                    cell_ff[8*p+:8] <= plane_wdata[8*p+:8];
                end
            end
        end
    end
    assign plane_rdata = cell_ff;
endmodule

// File: test/planar_graphics_datapath_checker.sv
// Purpose: Port-level assertions for the planar datapath
// Assumes: Register file mirrored from port writes
// Notes: Mirror resets to zero like the design
module gfx_checker #(
    parameter int ADDR_W = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [ADDR_W-1:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic io_rvalid,
    input wire logic fb_rd,
    input wire logic [1:0] fb_addr_lo,
    input wire logic [7:0] fb_rdata,
    input wire logic fb_rvalid,
    input wire logic odd_even_addr,
    input wire logic chain_four_addr,
    input wire logic [31:0] plane_rdata,
    input wire logic [7:0] latch_readback,
    input wire logic vid_load,
    input wire logic vid_xfer,
    input wire logic [3:0] serial_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] idx_ff;
    logic [7:0] gr_ff [16];
    logic idx_sel;
    logic dat_sel;

    // Colour compare; excluded planes always match
    function automatic logic [7:0] cmp8(input logic [31:0] d, input logic [3:0] c, m);
        cmp8 = 8'hff;
        for (int p = 0; p < 4; p++) begin
            if (m[p]) begin
                cmp8 &= ~(d[8*p+:8] ^ {8{c[p]}});
            end
        end
    endfunction

    // Mirror of index and data registers
    assign idx_sel = io_addr == ADDR_W'(gfx_pkg::INDEX_PORT);
    assign dat_sel = io_addr == ADDR_W'(gfx_pkg::DATA_PORT);
    always_ff @(posedge clk) begin
        if (srst) begin
            idx_ff <= 4'h0;
        end else if (io_wr && idx_sel) begin
            idx_ff <= io_wdata[3:0];
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            gr_ff <= '{default: 8'h00};
        end else if (io_wr && dat_sel) begin
            gr_ff[idx_ff] <= io_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    property p_io_rvalid; io_rd |=> io_rvalid; endproperty
    a_io_rvalid: assert property (p_io_rvalid) else $error("no read answer");
    property p_unmapped; io_rd && !idx_sel && !dat_sel |=> io_rvalid && io_rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_index; io_rd && idx_sel |=> io_rdata == {4'h0, $past(idx_ff)}; endproperty
    a_index: assert property (p_index) else $error("index readback wrong");
    property p_mode_rsv; io_rd && dat_sel && idx_ff == gfx_pkg::IDX_MODE |=> io_rdata == ($past(gr_ff[5]) & 8'h7b);
    endproperty
    a_mode_rsv: assert property (p_mode_rsv) else $error("mode reserved bits not zero");
    property p_rd_plane;
        fb_rd && !gr_ff[5][3] && !chain_four_addr && !odd_even_addr
            |=> fb_rdata == 8'($past(plane_rdata) >> {$past(gr_ff[4][1:0]), 3'b000});
    endproperty
    a_rd_plane: assert property (p_rd_plane) else $error("plane read wrong");
    property p_chain; fb_rd && !gr_ff[5][3] && chain_four_addr
        |=> fb_rdata == 8'($past(plane_rdata) >> {$past(fb_addr_lo), 3'b000}); endproperty
    a_chain: assert property (p_chain) else $error("chain read wrong");
    property p_latch; fb_rd ##1 (!fb_rd && !io_wr)
        |=> latch_readback == 8'($past(plane_rdata, 2) >> {gr_ff[4][1:0], 3'b000}); endproperty
    a_latch: assert property (p_latch) else $error("latch readback wrong");
    property p_compare; fb_rd && gr_ff[5][3]
        |=> fb_rdata == cmp8($past(plane_rdata), $past(gr_ff[2][3:0]), $past(gr_ff[7][3:0])); endproperty
    a_compare: assert property (p_compare) else $error("compare read wrong");
    property p_fb_rvalid; fb_rd |=> fb_rvalid; endproperty
    a_fb_rvalid: assert property (p_fb_rvalid) else $error("no frame read answer");
    property p_ser_hold; !vid_xfer && !vid_load |=> $stable(serial_out); endproperty
    a_ser_hold: assert property (p_ser_hold) else $error("serial output moved");
endmodule

bind planar_graphics_datapath gfx_checker #(.ADDR_W(ADDR_W)) u_gfx_checker (.*);

// File: test/tb.sv
// Purpose: Self-checking bench for the planar datapath
// Assumes: Inputs change on the falling clock edge
// Notes: Write rows chain, each latch after row 0 is the previous result
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [1:0] wm;
        logic [4:0] rop;
        logic [3:0] en;
        logic [3:0] val;
        logic [7:0] msk;
        logic [7:0] d;
        logic [31:0] exp;
    } row_t;
    // Write mode, fn/rotate, fill enable, fill value, bit mask, data, planes 3..0
    localparam row_t ROWS [8] = '{
        {2'h0, 5'h00, 4'h0, 4'h0, 8'hff, 8'ha5, 32'ha5a5_a5a5}, {2'h0, 5'h03, 4'h0, 4'h0, 8'hff, 8'h81, 32'h3030_3030},
        {2'h0, 5'h19, 4'h5, 4'h4, 8'hff, 8'h0f, 32'hb7cf_b730}, {2'h0, 5'h08, 4'h0, 4'h0, 8'hf0, 8'h3c, 32'h370f_3730},
        {2'h0, 5'h10, 4'h0, 4'h0, 8'hff, 8'h40, 32'h774f_7770}, {2'h1, 5'h18, 4'hf, 4'h0, 8'hff, 8'h00, 32'h774f_7770},
        {2'h2, 5'h00, 4'hf, 4'h0, 8'h0f, 8'h05, 32'h704f_707f}, {2'h3, 5'h02, 4'h0, 4'h9, 8'h3c, 8'hf0, 32'h7c43_407f}};
    localparam logic [3:0] RI [4] = '{4'h3, 4'h4, 4'h5, 4'h9};
    localparam logic [7:0] RE [4] = '{8'h1f, 8'h03, 8'h7b, 8'h00};
    logic clk, srst, io_mem_space, io_wr, io_rd, fb_wr, fb_rd, odd_even_addr, chain_four_addr, vid_load, vid_xfer;
    logic [15:0] io_addr;
    logic [7:0] io_wdata, fb_wdata, io_rdata, fb_rdata, latch_readback, rd_q;
    logic [1:0] fb_addr_lo;
    logic [3:0] plane_write_mask, plane_we, serial_out;
    logic io_rvalid, fb_rvalid;
    logic [31:0] plane_rdata, plane_wdata, mem_q;
    int mismatches, cmp_count;

    planar_graphics_datapath DUT (.*);
    plane_store mem (.*);

    ////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask
    task automatic wr1(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
    endtask
    task automatic reg_wr(input logic [3:0] i, input logic [7:0] v);
        wr1(gfx_pkg::INDEX_PORT, {4'h0, i});
        wr1(gfx_pkg::DATA_PORT, v);
    endtask
    // Answer is due exactly one cycle after the strobe
    task automatic io_read(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge clk);
        io_rd = 1'b0;
        chk("io_rvalid", 32'h1, io_rvalid);
        d = io_rdata;
    endtask
    task automatic fb_read(output logic [7:0] d);
        @(negedge clk);
        fb_rd = 1'b1;
        @(negedge clk);
        fb_rd = 1'b0;
        chk("fb_rvalid", 32'h1, fb_rvalid);
        d = fb_rdata;
    endtask
    // Expected serializer transfer k
    function automatic logic [3:0] ser_exp(input logic [1:0] sh, input int k, input logic [31:0] w);
        int j;
        j = 7 - 2 * (k % 4);
        if (sh == 2'h0) return {w[31-k], w[23-k], w[15-k], w[7-k]};
        if (sh == 2'h1) return (k < 4) ? {w[16+j], w[15+j], w[j], w[j-1]} : {w[24+j], w[23+j], w[8+j], w[7+j]};
        return k[0] ? w[8*(k/2)+:4] : w[8*(k/2)+4+:4];
    endfunction

    ////////////////////////////////////////////////////////////////
    initial begin
        {srst, io_mem_space, io_wr, io_rd, fb_wr, fb_rd, odd_even_addr, chain_four_addr, vid_load, vid_xfer} = 10'h200;
        io_addr = 16'h0000;
        {io_wdata, fb_wdata, fb_addr_lo} = 18'h0_0000;
        plane_write_mask = 4'hf;
        {mismatches, cmp_count} = 64'h0;
        repeat (4) @(negedge clk);
        srst = 1'b0;
        chk("reset outputs", 32'h0, {io_rdata, latch_readback, plane_we, serial_out});
        io_read(gfx_pkg::INDEX_PORT, rd_q);
        chk("index after reset", 32'h0, rd_q);
        // Reserved bits in both spaces; unmapped index 9 reads back as zero
        for (int i = 0; i < 4; i++) begin
            io_mem_space = i[0];
            reg_wr(RI[i], 8'hff);
            io_read(gfx_pkg::DATA_PORT, rd_q);
            chk("reg readback", RE[i], rd_q);
        end
        io_mem_space = 1'b0;
        wr1(gfx_pkg::INDEX_PORT, 8'hff);
        io_read(gfx_pkg::INDEX_PORT, rd_q);
        chk("index field", 32'h0f, rd_q);
        io_read(16'h03cd, rd_q);
        chk("unmapped read", 32'h0, rd_q);
        // Write path rows: load latches by a read, then write
        foreach (ROWS[r]) begin
            reg_wr(gfx_pkg::IDX_FILL_VALUE, {4'h0, ROWS[r].val});
            reg_wr(gfx_pkg::IDX_FILL_ENABLE, {4'h0, ROWS[r].en});
            reg_wr(gfx_pkg::IDX_ROTATE_OP, {3'h0, ROWS[r].rop});
            reg_wr(gfx_pkg::IDX_MODE, {6'h00, ROWS[r].wm});
            reg_wr(gfx_pkg::IDX_BIT_MASK, ROWS[r].msk);
            fb_read(rd_q);
            @(negedge clk);
            fb_wdata = ROWS[r].d;
            fb_wr = 1'b1;
            @(negedge clk);
            fb_wr = 1'b0;
            chk("plane_we", 32'hf, plane_we);
            chk("plane_wdata", ROWS[r].exp, plane_wdata);
            mem_q = ROWS[r].exp;
        end
        // Plain reads per plane, latch readback one cycle later
        reg_wr(gfx_pkg::IDX_MODE, 8'h00);
        for (int s = 0; s < 4; s++) begin
            reg_wr(gfx_pkg::IDX_READ_PLANE, 8'(s));
            fb_read(rd_q);
            chk("plane read", mem_q[8*s+:8], rd_q);
            @(negedge clk);
            chk("latch_readback", mem_q[8*s+:8], latch_readback);
        end
        chain_four_addr = 1'b1;
        fb_addr_lo = 2'h2;
        fb_read(rd_q);
        chk("chain read", mem_q[23:16], rd_q);
        {chain_four_addr, odd_even_addr, fb_addr_lo} = 4'h4;
        reg_wr(gfx_pkg::IDX_READ_PLANE, 8'h01);
        fb_read(rd_q);
        chk("odd even read", mem_q[7:0], rd_q);
        odd_even_addr = 1'b0;
        // Colour compare with all planes, then plane 0 only
        reg_wr(gfx_pkg::IDX_MODE, 8'h08);
        reg_wr(gfx_pkg::IDX_COMPARE, 8'h09);
        reg_wr(gfx_pkg::IDX_IGNORE, 8'h0f);
        fb_read(rd_q);
        chk("compare all", 32'h3c, rd_q);
        reg_wr(gfx_pkg::IDX_IGNORE, 8'h01);
        fb_read(rd_q);
        chk("compare one", 32'h7f, rd_q);
        // Serializer, every shift format
        for (int sh = 0; sh < 4; sh++) begin
            reg_wr(gfx_pkg::IDX_MODE, {1'b0, 2'(sh), 5'h00});
            @(negedge clk);
            vid_load = 1'b1;
            @(negedge clk);
            vid_load = 1'b0;
            vid_xfer = 1'b1;
            for (int k = 0; k < 8; k++) begin
                @(negedge clk);
                chk("serial_out", ser_exp(2'(sh), k, mem_q), serial_out);
            end
            vid_xfer = 1'b0;
        end
        report_and_stop();
    end
endmodule
